// >>> design/cell_policing_action_unit.sv
// Per-connection cell policing, tagging, selective discard and congestion marking
`timescale 1ns/100ps
module cell_policing_action_unit (
  input wire logic clk_in,
  input wire logic resetn_in,
  // Arriving cell header with conformance verdicts
  input wire logic cell_valid_in,
  output logic cell_ready_out,
  input wire logic [cell_police_pkg::HDR_W-1:0] cell_hdr_in,
  input wire logic [cell_police_pkg::CONN_W-1:0] cell_conn_in,
  input wire logic cell_oam_in,
  input wire logic cell_eof_in,
  input wire logic clp0_ok_in,
  input wire logic agg_ok_in,
  input wire logic frame_ok_in,
  input wire logic conn_active_in,
  // Per-connection configuration
  input wire logic [cell_police_pkg::CONN_N-1:0] enforce_en_in,
  input wire logic [cell_police_pkg::CONN_N-1:0] tag_req_in,
  input wire logic [cell_police_pkg::CONN_N-1:0] clp1_resv_in,
  input wire logic [cell_police_pkg::CONN_N-1:0] gfr_tag_in,
  input wire logic [cell_police_pkg::CONN_N-1:0] release_en_in,
  input wire logic net_tag_support_in,
  input wire logic oam_separate_in,
  // Congestion state and selective discard configuration
  input wire logic congested_in,
  input wire logic near_capacity_in,
  input wire logic efci_mark_en_in,
  input wire logic sd_noncompliant_en_in,
  input wire logic sd_clp1_en_in,
  // Departing cell toward the switch
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [cell_police_pkg::HDR_W-1:0] out_hdr_out,
  output logic [cell_police_pkg::CONN_W-1:0] out_conn_out,
  // Events
  output logic release_req_out,
  output logic [cell_police_pkg::CONN_W-1:0] release_conn_out,
  output logic drop_pulse_out,
  output logic tag_pulse_out,
  output logic [cell_police_pkg::CONN_N-1:0] noncompliant_out
);
  localparam int unsigned HW = cell_police_pkg::HDR_W;
  localparam int unsigned CW = cell_police_pkg::CONN_W;
  localparam int unsigned BW = HW + CW;

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1: capture cell and verdicts
  logic s1_valid, next_s1_valid;
  logic [HW-1:0] s1_hdr, next_s1_hdr;
  logic [CW-1:0] s1_conn, next_s1_conn;
  logic s1_oam, s1_eof, s1_clp0_ok, s1_agg_ok, s1_frame_ok, s1_active;
  logic next_s1_oam, next_s1_eof, next_s1_clp0_ok, next_s1_agg_ok;
  logic next_s1_frame_ok, next_s1_active;
  logic advance;
  logic buf_in_ready;

  // Pipeline stalls as a whole when the buffer cannot take a cell
  assign advance = buf_in_ready;
  assign cell_ready_out = advance;

  // Capture on accept, the three verdicts taken with the cell
  always_comb begin
    next_s1_valid = s1_valid;
    next_s1_hdr = s1_hdr;
    next_s1_conn = s1_conn;
    next_s1_oam = s1_oam;
    next_s1_eof = s1_eof;
    next_s1_clp0_ok = s1_clp0_ok;
    next_s1_agg_ok = s1_agg_ok;
    next_s1_frame_ok = s1_frame_ok;
    next_s1_active = s1_active;
    if (advance) begin
      next_s1_valid = cell_valid_in;
      next_s1_hdr = cell_hdr_in;
      next_s1_conn = cell_conn_in;
      next_s1_oam = cell_oam_in;
      next_s1_eof = cell_eof_in;
      next_s1_clp0_ok = clp0_ok_in;
      next_s1_agg_ok = agg_ok_in;
      next_s1_frame_ok = frame_ok_in;
      next_s1_active = conn_active_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_valid <= 1'b0;
      s1_hdr <= '0;
      s1_conn <= '0;
      s1_oam <= 1'b0;
      s1_eof <= 1'b0;
      s1_clp0_ok <= 1'b0;
      s1_agg_ok <= 1'b0;
      s1_frame_ok <= 1'b0;
      s1_active <= 1'b0;
    end else begin
      s1_valid <= next_s1_valid;
      s1_hdr <= next_s1_hdr;
      s1_conn <= next_s1_conn;
      s1_oam <= next_s1_oam;
      s1_eof <= next_s1_eof;
      s1_clp0_ok <= next_s1_clp0_ok;
      s1_agg_ok <= next_s1_agg_ok;
      s1_frame_ok <= next_s1_frame_ok;
      s1_active <= next_s1_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-connection frame state: frame marked ineligible until its last cell
  logic [cell_police_pkg::CONN_N-1:0] frame_bad, next_frame_bad;
  logic [cell_police_pkg::CONN_N-1:0] nc_flag, next_nc_flag;

  // Decision terms
  logic en_c, tag_c, gfr_c, clp_in, policed, clp0_fail, agg_fail, in_bad_frame;
  logic tag_ok, noncompliant;
  cell_police_pkg::action_t act;
  logic [HW-1:0] new_hdr;
  logic next_release, next_drop, next_tag;
  logic [CW-1:0] next_release_conn;

  always_comb begin
    en_c = enforce_en_in[s1_conn];
    // Tagging effective only with network support and CLP1 resources
    tag_c = tag_req_in[s1_conn] && net_tag_support_in && clp1_resv_in[s1_conn];
    gfr_c = gfr_tag_in[s1_conn] && tag_c;
    clp_in = s1_hdr[cell_police_pkg::CLP_POS];
    // Maintenance cells bypass policing when policed as a separate flow
    policed = en_c && !(s1_oam && oam_separate_in);
    clp0_fail = !clp_in && !s1_clp0_ok;
    agg_fail = !s1_agg_ok;
    in_bad_frame = frame_bad[s1_conn] || !s1_frame_ok;
    tag_ok = tag_c && !clp_in;
    noncompliant = 1'b0;
    new_hdr = s1_hdr;
    act = cell_police_pkg::ACT_PASS;
    if (!s1_active) begin
      act = cell_police_pkg::ACT_DROP;
    end else if (policed && agg_fail) begin
      act = cell_police_pkg::ACT_DROP;
      noncompliant = 1'b1;
    end else if (policed && clp0_fail) begin
      noncompliant = 1'b1;
      if (tag_ok) begin
        act = cell_police_pkg::ACT_TAG;
      end else begin
        act = cell_police_pkg::ACT_DROP;
      end
    end else if (policed && gfr_c && in_bad_frame && !clp_in && !s1_oam) begin
      act = cell_police_pkg::ACT_TAG;
    end
    // Selective discard while congested
    if (s1_active && congested_in && act != cell_police_pkg::ACT_DROP) begin
      if ((sd_noncompliant_en_in && (nc_flag[s1_conn] || noncompliant)) ||
          (sd_clp1_en_in && (clp_in || act == cell_police_pkg::ACT_TAG))) begin
        act = cell_police_pkg::ACT_DROP;
      end
    end
    if (act == cell_police_pkg::ACT_TAG) begin
      new_hdr[cell_police_pkg::CLP_POS] = 1'b1;
    end
    // Forward congestion mark on user data cells only
    if ((congested_in || near_capacity_in) && efci_mark_en_in &&
        !s1_hdr[cell_police_pkg::USER_POS]) begin
      new_hdr[cell_police_pkg::EFCI_POS] = 1'b1;
    end // otherwise header bit kept as received
    // Frame state and flags update only when the cell moves on
    next_frame_bad = frame_bad;
    next_nc_flag = nc_flag;
    next_release = 1'b0;
    next_drop = 1'b0;
    next_tag = 1'b0;
    next_release_conn = release_conn_out;
    if (advance && s1_valid && s1_active) begin
      next_frame_bad[s1_conn] = in_bad_frame && !s1_eof;
      if (noncompliant) begin
        next_nc_flag[s1_conn] = 1'b1;
        if (release_en_in[s1_conn] && !nc_flag[s1_conn]) begin
          next_release = 1'b1;
          next_release_conn = s1_conn;
        end
      end
    end
    if (advance && s1_valid) begin
      next_drop = (act == cell_police_pkg::ACT_DROP);
      next_tag = (act == cell_police_pkg::ACT_TAG);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_bad <= cell_police_pkg::CFG_RST;
      nc_flag <= cell_police_pkg::CFG_RST;
      release_req_out <= 1'b0;
      release_conn_out <= '0;
      drop_pulse_out <= 1'b0;
      tag_pulse_out <= 1'b0;
    end else begin
      frame_bad <= next_frame_bad;
      nc_flag <= next_nc_flag;
      release_req_out <= next_release;
      release_conn_out <= next_release_conn;
      drop_pulse_out <= next_drop;
      tag_pulse_out <= next_tag;
    end
  end

  assign noncompliant_out = nc_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Stage 2: decided cell into the in-order buffer, fixed two stages
  logic s2_valid, next_s2_valid;
  logic [BW-1:0] s2_data, next_s2_data;

  always_comb begin
    next_s2_valid = s2_valid;
    next_s2_data = s2_data;
    if (advance) begin
      next_s2_valid = s1_valid && (act != cell_police_pkg::ACT_DROP);
      next_s2_data = {s1_conn, new_hdr};
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s2_valid <= 1'b0;
      s2_data <= '0;
    end else begin
      s2_valid <= next_s2_valid;
      s2_data <= next_s2_data;
    end
  end

  // Single FIFO keeps arrival order across all connections
  logic [BW-1:0] buf_out;
  cell_skid_buffer #(
    .WIDTH(BW)
  ) u_buf (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(s2_valid && advance),
    .in_ready_out(buf_in_ready),
    .in_data_in(s2_data),
    .out_valid_out(out_valid_out),
    .out_ready_in(out_ready_in),
    .out_data_out(buf_out)
  );

  assign out_hdr_out = buf_out[HW-1:0];
  assign out_conn_out = buf_out[BW-1:HW];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_fail_accepted;
    advance && s1_valid && s1_active && policed && agg_fail;
  endsequence

  a_agg_drop: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_fail_accepted |=> drop_pulse_out && !s2_valid)
    else $error("aggregate failure not dropped");
  a_tag_only_clp0: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (advance && s1_valid && clp_in) |=> !tag_pulse_out)
    else $error("tag on clp1 cell");
  a_tag_sets_clp: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (advance && s1_valid && act == cell_police_pkg::ACT_TAG) |=>
    s2_valid && s2_data[cell_police_pkg::CLP_POS])
    else $error("tagged cell lacks clp");
  a_pass_same: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (advance && s1_valid && act == cell_police_pkg::ACT_PASS && !congested_in
     && !near_capacity_in) |=> s2_valid && s2_data[HW-1:0] == $past(s1_hdr))
    else $error("passed header changed");
  a_inactive_drop: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (advance && s1_valid && !s1_active) |=> !s2_valid)
    else $error("inactive cell forwarded");
  a_tag_needs_cfg: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tag_pulse_out |-> $past(tag_c))
    else $error("tag without enable");
  a_congest_clp1: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (advance && s1_valid && congested_in && sd_clp1_en_in && clp_in) |=> !s2_valid)
    else $error("clp1 cell kept in congestion");
  // Back to back requests are legal only for different connections
  a_release_once: assert property (@(posedge clk_in) disable iff (!resetn_in)
    release_req_out |=> !release_req_out || release_conn_out != $past(release_conn_out))
    else $error("release held");
  a_stall_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!advance && s2_valid) |=> s2_valid && $stable(s2_data))
    else $error("stage moved in stall");
  a_drop_gone: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (advance && s1_valid && act == cell_police_pkg::ACT_DROP) |=>
    !s2_valid && drop_pulse_out)
    else $error("dropped cell forwarded");
  a_efci_keep: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (advance && s1_valid && !congested_in && !near_capacity_in) |=>
    s2_data[cell_police_pkg::EFCI_POS] == $past(s1_hdr[cell_police_pkg::EFCI_POS]))
    else $error("congestion bit changed");
  a_release_flagged: assert property (@(posedge clk_in) disable iff (!resetn_in)
    release_req_out |->
    nc_flag[release_conn_out] && $past(advance && s1_valid && noncompliant))
    else $error("release without non-compliance");
endmodule : cell_policing_action_unit

// >>> design/cell_skid_buffer.sv
// Two-entry in-order buffer with valid and ready on both sides
`timescale 1ns/100ps
module cell_skid_buffer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] mem [2];
  logic [WIDTH-1:0] next_mem [2];
  logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [1:0] count, next_count;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes and next state
  always_comb begin
    in_ready_out = (count != 2'd2);
    out_valid_out = (count != 2'd0);
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = in_data_in;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    next_count = count + 2'(push) - 2'(pop);
  end

  // Registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem[0] <= '0;
      mem[1] <= '0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      mem <= next_mem;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end

  // Output data from the head flip-flop entry
  assign out_data_out = mem[rd_ptr];

  a_count_bound: assert property (@(posedge clk_in) disable iff (!resetn_in)
    count <= 2'd2) else $error("buffer count out of range");
endmodule : cell_skid_buffer

// >>> inc/cell_police_pkg.sv
// Shared constants and types for the cell policing stage
package cell_police_pkg;
  // Cell header and connection table geometry
  localparam int unsigned CELL_W = 424;
  localparam int unsigned CONN_W = 4;
  localparam int unsigned CONN_N = 16;
  localparam int unsigned VPI_W = 8;
  localparam int unsigned VCI_W = 16;
  // Header field positions within the 32-bit header word (GFC/VPI/VCI/PT/CLP)
  localparam int unsigned HDR_W = 32;
  localparam int unsigned CLP_POS = 0;
  localparam int unsigned PT_LSB = 1;
  localparam int unsigned EFCI_POS = 2;
  localparam int unsigned EOF_POS = 1;
  localparam int unsigned USER_POS = 3;
  localparam int unsigned VCI_LSB = 4;
  localparam int unsigned VPI_LSB = 20;
  // Fixed decision latency in cycles, verdict to output buffer
  localparam int unsigned DECIDE_LAT = 2;
  // Reset value of the per-connection frame and non-compliance flags
  localparam logic [CONN_N-1:0] CFG_RST = 16'h0000;

  // Action taken on a cell
  typedef enum logic [1:0] {
    ACT_PASS = 2'b00,
    ACT_TAG = 2'b01,
    ACT_DROP = 2'b10
  } action_t;
endpackage : cell_police_pkg

// >>> tb/cell_fabric_sink.sv
// Downstream fabric model that stalls at random or on command
`timescale 1ns/100ps
module cell_fabric_sink (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hold_in,
  output logic ready_out
);
  ////////////////////////////////////////////////////////////
  // Ready low while held, otherwise stalls about one cycle in four
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= !hold_in && ($urandom_range(3) != 0);
    end
  end
endmodule : cell_fabric_sink

// >>> tb/cell_policing_action_unit_test.sv
// Self-checking bench for the cell policing stage
`timescale 1ns/100ps
module cell_policing_action_unit_test;
  logic clk_in = 1'b0, resetn_in = 1'b0, cell_valid_in = 1'b0, hold = 1'b0;
  logic [31:0] cell_hdr_in = 32'h0;
  logic [3:0] cell_conn_in = 4'h0;
  logic cell_oam_in = 1'b0, oam_separate_in = 1'b0, cell_eof_in = 1'b0, clp0_ok_in = 1'b1;
  logic agg_ok_in = 1'b1, frame_ok_in = 1'b1, conn_active_in = 1'b1, net_tag_support_in = 1'b0;
  logic [15:0] enforce_en_in = 16'h0, tag_req_in = 16'h0, clp1_resv_in = 16'h0;
  logic [15:0] gfr_tag_in = 16'h0, release_en_in = 16'h0;
  logic congested_in = 1'b0, near_capacity_in = 1'b0, efci_mark_en_in = 1'b0;
  logic sd_noncompliant_en_in = 1'b0, sd_clp1_en_in = 1'b0;
  logic cell_ready_out, out_valid_out, out_ready_in, release_req_out, drop_pulse_out, tag_pulse_out;
  logic [31:0] out_hdr_out;
  logic [3:0] out_conn_out, release_conn_out, rel_conn;
  logic [15:0] noncompliant_out;
  logic [35:0] exp_q[$];
  int err_total = 0, comparisons = 0, drops_exp = 0, tags_exp = 0, drops_seen = 0, tags_seen = 0;
  int rel_seen = 0, n, seed;
  bit frame_bad[16], ncomp[16], t;
  ////////////////////////////////////////////////////////////
  // Design, far-side model and clock
  cell_policing_action_unit dut (.clk_in, .resetn_in, .cell_valid_in, .cell_ready_out, .cell_hdr_in,
    .cell_conn_in, .cell_oam_in, .cell_eof_in, .clp0_ok_in, .agg_ok_in, .frame_ok_in,
    .conn_active_in, .enforce_en_in, .tag_req_in, .clp1_resv_in, .gfr_tag_in, .release_en_in,
    .net_tag_support_in, .oam_separate_in, .congested_in, .near_capacity_in, .efci_mark_en_in,
    .sd_noncompliant_en_in, .sd_clp1_en_in, .out_valid_out, .out_ready_in, .out_hdr_out,
    .out_conn_out, .release_req_out, .release_conn_out, .drop_pulse_out, .tag_pulse_out,
    .noncompliant_out);
  cell_fabric_sink sink (.clk_in, .resetn_in, .hold_in(hold), .ready_out(out_ready_in));
  initial forever #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // Reference model of one taken cell
  task automatic model(input logic [31:0] h, input logic [3:0] c, input logic v0, va, vf, ve, act);
    logic drop;
    logic tag;
    logic en;
    logic tag_on;
    en = enforce_en_in[c] && !(cell_oam_in && oam_separate_in);
    tag_on = tag_req_in[c] && net_tag_support_in && clp1_resv_in[c];
    tag = 1'b0;
    drop = !act || (en && !va);
    frame_bad[c] = frame_bad[c] | (act && !vf);
    if (!drop && en && !v0 && !h[0]) begin
      tag = tag_on;
      drop = !tag;
    end
    if (act && en && (!va || (!v0 && !h[0]))) ncomp[c] = 1'b1;
    if (!drop && !tag && en && tag_on && gfr_tag_in[c] && frame_bad[c] && !h[0] &&
        !cell_oam_in) tag = 1'b1;
    if (ve && act) frame_bad[c] = 1'b0;
    if (tag) h[0] = 1'b1;
    if (congested_in && ((sd_clp1_en_in && h[0]) || (sd_noncompliant_en_in && ncomp[c]))) begin
      drop = 1'b1;
      tag = 1'b0;
    end
    if ((congested_in || near_capacity_in) && efci_mark_en_in && !h[3]) h[2] = 1'b1;
    drops_exp += drop;
    tags_exp += tag;
    if (!drop) exp_q.push_back({h, c});
  endtask : model
  // Offer one cell, hold it until taken or refused too long
  task automatic send(input logic [31:0] h, input logic [3:0] c, input logic v0, va, vf, ve, act,
                      output bit took);
    cell_valid_in <= 1'b1;
    cell_hdr_in <= h;
    cell_conn_in <= c;
    {clp0_ok_in, agg_ok_in, frame_ok_in, cell_eof_in, conn_active_in} <= {v0, va, vf, ve, act};
    took = 1'b0;
    for (int i = 0; i < 30 && !took; i++) begin
      @(posedge clk_in);
      took = (cell_ready_out === 1'b1);
    end
    if (took) model(h, c, v0, va, vf, ve, act);
  endtask : send
  task automatic go(input logic [31:0] h, input logic [3:0] c, input logic v0 = 1, va = 1,
                    vf = 1, ve = 1);
    send(h, c, v0, va, vf, ve, 1'b1, t);
    if (!t) begin
      err_total++;
      report_and_stop();
    end
  endtask : go
  // Wait for all expected cells, then for the last pulses
  task automatic drain();
    cell_valid_in <= 1'b0;
    for (int i = 0; i < 400 && (exp_q.size() != 0 || out_valid_out !== 1'b0); i++) @(posedge clk_in);
    repeat (cell_police_pkg::DECIDE_LAT + 1) @(posedge clk_in);
    if (exp_q.size() != 0) begin
      err_total++;
      report_and_stop();
    end
  endtask : drain
  task automatic finish_test(input string name);
    drain();
    check(drops_seen, drops_exp);
    check(tags_seen, tags_exp);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask : finish_test
  ////////////////////////////////////////////////////////////
  // Output monitor and event counters
  always @(posedge clk_in) begin
    if (resetn_in && out_valid_out === 1'b1 && out_ready_in === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0);
      else check({out_hdr_out, out_conn_out}, exp_q.pop_front());
    end
    if (drop_pulse_out === 1'b1) drops_seen++;
    if (tag_pulse_out === 1'b1) tags_seen++;
    if (release_req_out === 1'b1) begin
      rel_seen++;
      rel_conn = release_conn_out;
    end
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = $urandom(32'hda37);
    repeat (10) @(posedge clk_in);
    check({cell_ready_out, out_valid_out, release_req_out, noncompliant_out}, 36'h4_0000);
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    {enforce_en_in, tag_req_in, clp1_resv_in, net_tag_support_in} <= {48'hffff_ffff_ffff, 1'b1};
    @(posedge clk_in);
    // Same latency for passed and tagged cells
    for (int k = 0; k < 2; k++) begin
      go(32'h0000_1230, 4'h2, k[0] ? 1'b0 : 1'b1);
      cell_valid_in <= 1'b0;
      // Look just after each edge, once the buffer count has settled
      for (n = 0; n < 10 && out_valid_out !== 1'b1; n++) begin
        @(posedge clk_in);
        #1;
      end
      check(n, cell_police_pkg::DECIDE_LAT);
      drain();
    end
    finish_test("latency");
    // Release request once, then discard of the non-compliant connection
    release_en_in <= 16'h0020;
    go(32'h0000_0050, 4'h5, 1, 0);
    go(32'h0000_0051, 4'h5, 1, 0);
    finish_test("release");
    check(rel_seen, 1);
    check(rel_conn, 4'h5);
    {congested_in, sd_noncompliant_en_in} <= 2'b11;
    go(32'h0000_0050, 4'h5);
    go(32'h0000_0060, 4'h6);
    finish_test("noncompliant discard");
    check(noncompliant_out[6:5], 2'b01);
    {congested_in, sd_noncompliant_en_in} <= 2'b00;
    // Maintenance cell policed apart, then together with data
    {oam_separate_in, cell_oam_in} <= 2'b11;
    go(32'h0000_0040, 4'h4, 1, 0);
    finish_test("oam separate");
    check(noncompliant_out[4], 1'b0);
    oam_separate_in <= 1'b0;
    go(32'h0000_0040, 4'h4, 1, 0);
    cell_oam_in <= 1'b0;
    finish_test("oam together");
    check(noncompliant_out[4], 1'b1);
    // Frame-ineligible frame tagged to its end
    gfr_tag_in <= 16'h0080;
    for (int i = 0; i < 5; i++) begin
      go({28'h0000_070, 3'b000, i == 2}, 4'h7, 1, 1, i != 1, i > 2);
    end
    finish_test("frame tag");
    // Fill while the fabric stalls, then drain in order
    hold <= 1'b1;
    n = 0;
    t = 1'b1;
    while (t && n < 10) begin
      send($urandom & 32'hffff_fff6, 4'h3, 1, 1, 1, 1, 1, t);
      n += t;
    end
    check(n >= 2 && !t, 1);
    hold <= 1'b0;
    finish_test("buffer full");
    // Random traffic over random configurations
    for (int b = 0; b < 8; b++) begin
      enforce_en_in <= 16'($urandom);
      tag_req_in <= 16'($urandom);
      clp1_resv_in <= 16'($urandom);
      gfr_tag_in <= 16'($urandom);
      net_tag_support_in <= b[0];
      {congested_in, near_capacity_in, efci_mark_en_in} <= 3'($urandom);
      sd_clp1_en_in <= b[1];
      sd_noncompliant_en_in <= b[2];
      @(posedge clk_in);
      for (int i = 0; i < 40; i++) begin
        seed = $urandom;
        send(seed, 4'($urandom), seed[0] | ($urandom_range(2) != 0),
             $urandom_range(4) != 0, $urandom_range(5) != 0, 1'($urandom_range(1)),
             $urandom_range(9) != 0, t);
        if (!t) begin
          err_total++;
          report_and_stop();
        end
      end
      finish_test("random batch");
    end
    report_and_stop();
  end
endmodule : cell_policing_action_unit_test
